// ### hdl/sccl_pkg.sv
package sccl_pkg;

   // Percent settings
   localparam int unsigned     PCT_W          = 7;
   localparam logic [6:0]      PCT_MAX        = 7'h64;   // 100 percent
   localparam logic [6:0]      ACCEL_PCT_RST  = 7'h19;   // 25 percent
   localparam logic [6:0]      RUN_PCT_RST    = 7'h19;   // 25 percent
   localparam logic [6:0]      HOLD_PCT_RST   = 7'h05;   // 5 percent

   // Delay settings in milliseconds
   localparam int unsigned     MS_W           = 16;
   localparam logic [15:0]     SETTLE_MS_RST  = 16'h0000;
   localparam logic [15:0]     HOLD_MS_RST    = 16'h0000;

   // Current reference width
   localparam int unsigned     REF_W          = 12;

   // Millisecond tick from the 200 MHz system clock
   localparam int unsigned     CLK_HZ         = 200_000_000;
   localparam int unsigned     MS_PER_S       = 1000;
   localparam int unsigned     TICK_CYC       = CLK_HZ / MS_PER_S;
   localparam int unsigned     TICK_W         = 18;

   // Motion state of the current selector
   typedef enum logic [2:0] {
      SCCL_IDLE_HOLD,
      SCCL_ACCEL,
      SCCL_RUN,
      SCCL_SETTLE,
      SCCL_HOLD_WAIT
   } sccl_state_t;

endpackage : sccl_pkg

// ### hdl/sccl_ms_timer.sv
`timescale 1ns/1ps

// Millisecond down-counter: prescaler plus a 16-bit millisecond count
module sccl_ms_timer
   import sccl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              clear,      // Stop and zero the timer
   input  wire logic              start,      // Load a new duration
   input  wire logic [MS_W-1:0]   dur_ms,     // Duration in milliseconds
   output logic                   done_q      // High once the duration has passed
);

   logic [TICK_W-1:0] pre_q;              // Cycles within one millisecond
   logic [MS_W-1:0]   ms_q;               // Milliseconds still to wait
   logic              run_q;              // Counting in progress
   logic              tick;               // Millisecond boundary

   localparam logic [TICK_W-1:0] PRE_LAST = TICK_W'(TICK_CYCLES - 1);

   assign tick = run_q && (pre_q == PRE_LAST);

   // Prescaler and millisecond count
   always_ff @(posedge clk_sys) begin
      if (!rst_b || clear) begin
         pre_q  <= '0;
         ms_q   <= '0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end else if (start) begin
         // A zero duration completes at once
         pre_q  <= '0;
         ms_q   <= dur_ms;
         run_q  <= (dur_ms != '0);
         done_q <= (dur_ms == '0);
      end else if (run_q) begin
         pre_q <= tick ? '0 : pre_q + 1'b1;
         if (tick) begin
            ms_q <= ms_q - 1'b1;
            if (ms_q == MS_W'(1)) begin
               run_q  <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

endmodule : sccl_ms_timer

// ### hdl/sccl_current_select.sv
`timescale 1ns/1ps

// What this block does
// - Velocity changing selects acceleration current percent
// - Peak constant velocity selects run current percent
// - Hold current from reset, otherwise only after settle then hold
// - Acceleration percent 0 to 100, resets 25
// - Run percent 0 to 100, resets 25
// - Hold percent 0 to 100, resets 5
// - Hold delay milliseconds, 0 to 65535, resets 0
// - Settle delay milliseconds, 0 to 65535, resets 0
module sccl_current_select
   import sccl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC   // Shorten for simulation
) (
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   // Motion profile generator (same clock)
   input  wire logic               vel_changing,     // Accelerating or decelerating
   input  wire logic               at_peak_vel,      // Constant peak velocity
   // Settings written by the host
   input  wire logic               accel_pct_wr,     // Write strobe
   input  wire logic               run_pct_wr,       // Write strobe
   input  wire logic               hold_pct_wr,      // Write strobe
   input  wire logic               settle_ms_wr,     // Write strobe
   input  wire logic               hold_ms_wr,       // Write strobe
   input  wire logic [PCT_W-1:0]   pct_wdata,        // Percent value
   input  wire logic [MS_W-1:0]    ms_wdata,         // Millisecond value
   input  wire logic [REF_W-1:0]   peak_ref,         // Full scale peak reference
   // Status and settings read back
   output logic [PCT_W-1:0]        accel_current_pct_q,
   output logic [PCT_W-1:0]        run_current_pct_q,
   output logic [PCT_W-1:0]        hold_current_pct_q,
   output logic [MS_W-1:0]         settle_delay_ms_q,
   output logic [MS_W-1:0]         hold_delay_ms_q,
   output logic                    holding_q,        // Hold current in force
   output logic [REF_W-1:0]        cur_ref_q         // Reference to chopping stage
);

   sccl_state_t        state_q;          // Present motion state
   sccl_state_t        state_d;          // Next motion state
   logic               moving;           // Any motion reported
   logic               settle_done;      // Settle timer expired
   logic               hold_done;        // Hold timer expired
   logic               settle_start;     // Load settle timer
   logic               hold_start;       // Load hold timer
   logic               tmr_clear;        // Abandon both timers
   logic [PCT_W-1:0]   prev_pct_q;       // Level kept while settling
   logic [PCT_W-1:0]   sel_pct;          // Percent chosen this cycle
   logic [REF_W-1:0]   ref_d;            // Scaled reference

   // Out-of-range writes are clipped so the setting stays 0 to 100
   function automatic logic [PCT_W-1:0] clip_pct(input logic [PCT_W-1:0] v);
      clip_pct = (v > PCT_MAX) ? PCT_MAX : v;
   endfunction : clip_pct

   // Scale a percent of the peak reference; truncates toward zero
   function automatic logic [REF_W-1:0] scale_ref(input logic [PCT_W-1:0] p,
                                                  input logic [REF_W-1:0] pk);
      logic [REF_W+PCT_W-1:0] prod;
      prod      = (REF_W+PCT_W)'(pk) * (REF_W+PCT_W)'(p);
      scale_ref = REF_W'(prod / (REF_W+PCT_W)'(PCT_MAX));
   endfunction : scale_ref

   assign moving = vel_changing || at_peak_vel;

   // Settings: host writes them, hardware only reads
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         accel_current_pct_q <= ACCEL_PCT_RST;
         run_current_pct_q   <= RUN_PCT_RST;
         hold_current_pct_q  <= HOLD_PCT_RST;
         settle_delay_ms_q   <= SETTLE_MS_RST;
         hold_delay_ms_q     <= HOLD_MS_RST;
      end else begin
         if (accel_pct_wr) begin
            accel_current_pct_q <= clip_pct(pct_wdata);
         end
         if (run_pct_wr) begin
            run_current_pct_q <= clip_pct(pct_wdata);
         end
         if (hold_pct_wr) begin
            hold_current_pct_q <= clip_pct(pct_wdata);
         end
         if (settle_ms_wr) begin
            settle_delay_ms_q <= ms_wdata;
         end
         if (hold_ms_wr) begin
            hold_delay_ms_q <= ms_wdata;
         end
      end
   end

   // Next state; velocity change outranks peak velocity
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SCCL_IDLE_HOLD, SCCL_SETTLE, SCCL_HOLD_WAIT: begin
            if (vel_changing || at_peak_vel) begin
               // Restart always begins on acceleration current
               state_d = SCCL_ACCEL;
            end else if (state_q == SCCL_SETTLE && settle_done) begin
               state_d = SCCL_HOLD_WAIT;
            end else if (state_q == SCCL_HOLD_WAIT && hold_done) begin
               state_d = SCCL_IDLE_HOLD;
            end
         end
         SCCL_ACCEL, SCCL_RUN: begin
            if (vel_changing) begin
               state_d = SCCL_ACCEL;
            end else if (at_peak_vel) begin
               state_d = SCCL_RUN;
            end else begin
               state_d = SCCL_SETTLE;
            end
         end
      endcase
   end

   // Timer control
   assign tmr_clear    = moving;
   assign settle_start = (state_q == SCCL_ACCEL || state_q == SCCL_RUN) && !moving;
   assign hold_start   = (state_q == SCCL_SETTLE) && settle_done && !moving;

   // Settle then hold timers; hold starts only when settle ends
   sccl_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_settle_tmr (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .clear   (tmr_clear),
      .start   (settle_start),
      .dur_ms  (settle_delay_ms_q),
      .done_q  (settle_done)
   );

   sccl_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_hold_tmr (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .clear   (tmr_clear),
      .start   (hold_start),
      .dur_ms  (hold_delay_ms_q),
      .done_q  (hold_done)
   );

   // Percent for the coming state; settling keeps the last moving level
   assign sel_pct = (state_d == SCCL_ACCEL) ? accel_current_pct_q :
                    (state_d == SCCL_RUN)   ? run_current_pct_q :
                    (state_d == SCCL_IDLE_HOLD) ? hold_current_pct_q :
                    prev_pct_q;

   assign ref_d = scale_ref(sel_pct, peak_ref);

   // State, kept level and registered reference
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_q    <= SCCL_IDLE_HOLD;
         prev_pct_q <= '0;
         holding_q  <= 1'b1;
         cur_ref_q  <= '0;
      end else begin
         state_q    <= state_d;
         prev_pct_q <= sel_pct;
         holding_q  <= (state_d == SCCL_IDLE_HOLD);
         cur_ref_q  <= ref_d;
      end
   end

   // Acceleration current follows velocity change by one clock
   chk_accel_level: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      vel_changing |=> cur_ref_q == scale_ref($past(accel_current_pct_q), $past(peak_ref)))
      else $error("accel current not applied");

   // Run state at steady peak velocity
   chk_run_level: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (at_peak_vel && !vel_changing) [*2] |=> state_q == SCCL_RUN)
      else $error("run state not reached");

   // No hold while settling or waiting
   chk_no_early_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (state_q == SCCL_SETTLE || state_q == SCCL_HOLD_WAIT) |-> !holding_q)
      else $error("hold current before delays ended");

   // Hold only after hold timer
   chk_hold_entry: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      $rose(holding_q) |-> $past(state_q) == SCCL_HOLD_WAIT && $past(hold_done))
      else $error("hold entered without delay");

   // Percent settings stay in range
   chk_pct_range: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      accel_current_pct_q <= PCT_MAX && run_current_pct_q <= PCT_MAX
      && hold_current_pct_q <= PCT_MAX)
      else $error("current percent above full scale");

   // Write lands next clock
   chk_hold_pct_wr: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      hold_pct_wr && pct_wdata <= PCT_MAX |=> hold_current_pct_q == $past(pct_wdata))
      else $error("hold percent write lost");

   // Delay write lands next clock
   chk_hold_ms_wr: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      hold_ms_wr |=> hold_delay_ms_q == $past(ms_wdata))
      else $error("hold delay write lost");

   // Settle write lands next clock
   chk_settle_ms_wr: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      settle_ms_wr |=> settle_delay_ms_q == $past(ms_wdata))
      else $error("settle delay write lost");

   // Restart aborts pending hold
   chk_restart_abort: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (state_q == SCCL_SETTLE || state_q == SCCL_HOLD_WAIT) && moving
      |=> state_q == SCCL_ACCEL && !settle_done && !hold_done)
      else $error("restart did not abort hold wait");

endmodule : sccl_current_select

// ### dv/sccl_motion_gen.sv
`timescale 1ns/1ps

// Motion profile generator and full-scale reference, one cycle behind its command
module sccl_motion_gen
   import sccl_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic [1:0]       phase_cmd,     // Bit 0 ramping, bit 1 cruising
   input  wire logic [REF_W-1:0] ref_cmd,       // Requested full-scale level
   output logic                  vel_changing,
   output logic                  at_peak_vel,
   output logic [REF_W-1:0]      peak_ref
);
   // Registered outputs, like a real generator on the same clock
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         vel_changing <= 1'b0;
         at_peak_vel  <= 1'b0;
      end else begin
         vel_changing <= phase_cmd[0];
         at_peak_vel  <= phase_cmd[1];
      end
      peak_ref <= ref_cmd;
   end
endmodule : sccl_motion_gen

// ### dv/tb.sv
`timescale 1ns/1ps

// Self-checking bench for the current level selector
module tb
   import sccl_pkg::*;
;
   localparam int unsigned TCK = 4;   // Short tick keeps delays to a few cycles
   logic              clk_sys   = 1'b0;
   logic              rst_b     = 1'b0;
   logic [1:0]        phase_cmd = 2'h0;
   logic [REF_W-1:0]  ref_cmd   = 12'h800;
   logic [4:0]        wr_sel    = 5'h00;   // One strobe per setting
   logic [PCT_W-1:0]  pct_wdata = 7'h00;
   logic [MS_W-1:0]   ms_wdata  = 16'h0000;
   logic              vel_changing, at_peak_vel;
   logic [REF_W-1:0]  peak_ref, cur_ref_q;
   logic [PCT_W-1:0]  acc_q, run_q, hld_q;
   logic [MS_W-1:0]   set_ms_q, hld_ms_q;
   logic              holding_q;
   int                n_errors = 0;
   int                checked  = 0;
   int                seed     = 97382;
   int                cycles   = 0;
   int                pk, v, c;
   int                k_w;                // Kind taken by the watcher
   logic [15:0]       e_w;                // Expected value taken by the watcher
   int                pct_s[3];           // Shadow of the three percentages
   int                kind_q[$];          // Pending notes: which output
   logic [15:0]       exp_q[$];           // Pending notes: expected value
   string             nm[7] = '{"accel_pct", "run_pct", "hold_pct", "settle_ms",
                                "hold_ms", "holding", "cur_ref"};
   event              chk_ev;

   sccl_motion_gen u_sccl_motion_gen (.clk_sys(clk_sys), .rst_b(rst_b),
      .phase_cmd(phase_cmd), .ref_cmd(ref_cmd), .vel_changing(vel_changing),
      .at_peak_vel(at_peak_vel), .peak_ref(peak_ref));

   sccl_current_select #(.TICK_CYCLES(TCK)) u_sccl_current_select (.clk_sys(clk_sys),
      .rst_b(rst_b), .vel_changing(vel_changing), .at_peak_vel(at_peak_vel),
      .accel_pct_wr(wr_sel[0]), .run_pct_wr(wr_sel[1]), .hold_pct_wr(wr_sel[2]),
      .settle_ms_wr(wr_sel[3]), .hold_ms_wr(wr_sel[4]), .pct_wdata(pct_wdata),
      .ms_wdata(ms_wdata), .peak_ref(peak_ref), .accel_current_pct_q(acc_q),
      .run_current_pct_q(run_q), .hold_current_pct_q(hld_q),
      .settle_delay_ms_q(set_ms_q), .hold_delay_ms_q(hld_ms_q),
      .holding_q(holding_q), .cur_ref_q(cur_ref_q));

   // 200 MHz clock
   always #2.5 clk_sys = ~clk_sys;

   // Hang guard, far above the expected run length
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         close_out();
      end
   end

   task close_out;
      // Notes never compared count as one mismatch
      if (kind_q.size() != 0) n_errors++;
      $display("Errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   task cmp(input int k, input logic [15:0] e, input logic [15:0] got);
      checked++;
      if (got !== e) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", nm[k], e, got);
      end
   endtask : cmp

   // Hold flag compare
   task cmp_flag(input logic e, input logic got);
      checked++;
      if (got !== e) begin
         n_errors++;
         $display("[ERR] holding expected %0h seen %0h", e, got);
      end
   endtask : cmp_flag

   // Current reference compare
   task cmp_ref(input logic [REF_W-1:0] e, input logic [REF_W-1:0] got);
      checked++;
      if (got !== e) begin
         n_errors++;
         $display("[ERR] cur_ref expected %0h seen %0h", e, got);
      end
   endtask : cmp_ref

   // Watcher drains every pending note, so two notes in one step are not lost
   always @(chk_ev) begin
      while (kind_q.size() > 0) begin
         k_w = kind_q.pop_front();
         e_w = exp_q.pop_front();
         case (k_w)
            0: cmp(k_w, e_w, {9'h000, acc_q});
            1: cmp(k_w, e_w, {9'h000, run_q});
            2: cmp(k_w, e_w, {9'h000, hld_q});
            3: cmp(k_w, e_w, set_ms_q);
            4: cmp(k_w, e_w, hld_ms_q);
            5: cmp_flag(e_w[0], holding_q);
            default: cmp_ref(e_w[REF_W-1:0], cur_ref_q);
         endcase
      end
   end

   task note(input int k, input int e);
      kind_q.push_back(k);
      exp_q.push_back(e[15:0]);
      -> chk_ev;
   endtask : note

   // Truncating scale of the reference, worked out here
   function automatic int scaled(input int p);
      return (pk * p) / 100;
   endfunction : scaled

   // One-cycle write strobe, readback looked at after the next edge
   task wr(input int sel, input int val);
      @(posedge clk_sys);
      wr_sel    <= 5'h01 << sel;
      pct_wdata <= val[6:0];
      ms_wdata  <= val[15:0];
      @(posedge clk_sys);
      wr_sel    <= 5'h00;
      @(negedge clk_sys);
   endtask : wr

   // Set a motion phase and look at the level once it has passed through
   task move(input int ph, input int idx);
      @(posedge clk_sys);
      phase_cmd <= ph[1:0];
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      note(6, scaled(pct_s[idx]));
      note(5, 0);
   endtask : move

   // Stop, then the previous level must stand for n cycles
   task halt(input int n, input int idx);
      @(posedge clk_sys);
      phase_cmd <= 2'h0;
      repeat (n) begin
         @(negedge clk_sys);
         note(6, scaled(pct_s[idx]));
         note(5, 0);
      end
   endtask : halt

   // Bounded wait for the hold level
   task settle_out;
      c = 0;
      while (holding_q !== 1'b1 && c < 40) begin
         @(negedge clk_sys);
         c++;
      end
      note(5, 1);
      repeat (2) @(negedge clk_sys);
      note(6, scaled(pct_s[2]));
   endtask : settle_out

   // Main sequence
   initial begin
      pk      = 12'h800 | ($random(seed) & 12'h7FF);   // Large, so levels stay distinct
      ref_cmd <= pk[11:0];
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(negedge clk_sys);
      note(0, 25);
      note(1, 25);
      note(2, 5);
      note(3, 0);
      note(4, 0);
      note(5, 1);
      repeat (2) @(negedge clk_sys);
      note(6, (pk * 5) / 100);
      // Percent bounds, clipping, then distinct random levels
      for (int i = 0; i < 3; i++) begin
         wr(i, 127);
         note(i, 100);
         wr(i, 0);
         note(i, 0);
         v = (2 - i) * 33 + 1 + {$random(seed)} % 33;
         wr(i, v);
         pct_s[i] = v;
         note(i, v);
      end
      // Delay upper bound and a random value, then short delays
      for (int j = 3; j < 5; j++) begin
         wr(j, 16'hFFFF);
         note(j, 16'hFFFF);
         v = {$random(seed)} % 65536;
         wr(j, v);
         note(j, v);
      end
      wr(3, 3);
      wr(4, 2);
      move(1, 0);
      move(3, 0);
      move(2, 1);
      halt((3 + 2) * TCK, 1);
      settle_out();
      // Restart in mid settle, then a full stop proves the timers restarted
      move(2, 1);
      halt(6, 1);
      move(1, 0);
      halt((3 + 2) * TCK, 0);
      settle_out();
      // Zero delays with a new full-scale level
      pk = 12'h800 | ($random(seed) & 12'h7FF);
      @(posedge clk_sys);
      ref_cmd <= pk[11:0];
      wr(3, 0);
      wr(4, 0);
      move(2, 1);
      // Slowing down from peak uses the acceleration level
      move(1, 0);
      halt(1, 0);
      settle_out();
      // Let the watcher drain the last notes
      @(negedge clk_sys);
      close_out();
   end
endmodule : tb
